// *** src/shift_move_pkg.sv ***
package shift_move_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic NULL_RESET = 1'b0;
  localparam logic TARGET_ACC = 1'b0;
  localparam logic TARGET_REG = 1'b1;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_SHIFT_LEFT,
    OP_SHIFT_RIGHT,
    OP_COPY
  } op_type;

  typedef struct packed {
    op_type op;
    logic [6:0] addr;
    logic target_sel;
  } instr_type;

  typedef struct packed {
    logic write_en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_write_type;

endpackage

// *** src/shift_move_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

// ===========================================
// Combinational result generation
module shift_move_unit (
  input wire shift_move_pkg::op_type op, // Operation
  input wire logic [7:0] operand, // File register value
  input wire logic carry_in, // Current carry
  output logic [7:0] result, // Computed result
  output logic carry_out, // Next carry
  output logic carry_touch // Op writes carry
);

  always_comb begin
    result = operand;
    carry_out = carry_in;
    carry_touch = 1'b0;
    case (op)
      shift_move_pkg::OP_SHIFT_LEFT: begin
        result = {operand[6:0], 1'b0};
        carry_out = operand[7];
        carry_touch = 1'b1;
      end
      shift_move_pkg::OP_SHIFT_RIGHT: begin
        result = {1'b0, operand[7:1]};
        carry_out = operand[0];
        carry_touch = 1'b1;
      end
      shift_move_pkg::OP_COPY: begin
        result = operand;
      end
      default: begin
        result = operand;
      end
    endcase
  end

endmodule

`default_nettype wire

// *** src/shift_and_move_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Left shift, bit 7 to carry
// - Left shift fills bit 0 zero
// - Target select: 0 accumulator, 1 register
// - Right shift, bit 0 to carry
// - Right shift forces bit 7 zero
// - Seven-bit address, one target bit
// - Copy to accumulator or same register
// - Copy updates zero flag always
module shift_and_move_datapath (
  input wire logic clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire shift_move_pkg::instr_type instr, // Decoded instruction
  input wire logic [7:0] operand_data, // Addressed register value
  output logic [6:0] operand_addr, // Register file read address
  output shift_move_pkg::file_write_type file_write, // Write-back
  output logic [7:0] acc_value, // Accumulator
  output logic shift_out_bit, // Carry flag
  output logic null_result_flag // Zero flag
);

  // ===========================================
  // Result computation
  logic [7:0] result;
  logic carry_calc;
  logic carry_touch;
  logic active;

  assign operand_addr = instr.addr;
  assign active = instr.op != shift_move_pkg::OP_NONE;

  shift_move_unit u_unit (
    .op(instr.op),
    .operand(operand_data),
    .carry_in(shift_out_bit),
    .result(result),
    .carry_out(carry_calc),
    .carry_touch(carry_touch)
  );

  // ===========================================
  // Architectural state
  logic [7:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic zero_reg, zero_next;
  shift_move_pkg::file_write_type wr_reg, wr_next;

  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    wr_next = '0;
    if (active) begin
      // Copy with register target still rewrites, keeping timing uniform
      if (instr.target_sel == shift_move_pkg::TARGET_ACC) begin
        acc_next = result;
      end else begin
        wr_next.write_en = 1'b1;
        wr_next.addr = instr.addr;
        wr_next.data = result;
      end
      zero_next = (result == 8'h00);
      if (carry_touch) begin
        carry_next = carry_calc;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= shift_move_pkg::ACC_RESET;
      carry_reg <= shift_move_pkg::CARRY_RESET;
      zero_reg <= shift_move_pkg::NULL_RESET;
      wr_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      wr_reg <= wr_next;
    end
  end

  assign acc_value = acc_reg;
  assign shift_out_bit = carry_reg;
  assign null_result_flag = zero_reg;
  assign file_write = wr_reg;

  // ===========================================
  // Reference result for the checks
  // Kept apart from the unit so a slip there is not mirrored here
  function automatic logic [7:0] expect_result(
    input shift_move_pkg::op_type op,
    input logic [7:0] value
  );
    logic [7:0] res;
    res = value;
    case (op)
      shift_move_pkg::OP_SHIFT_LEFT: begin
        res = {value[6:0], 1'b0};
      end
      shift_move_pkg::OP_SHIFT_RIGHT: begin
        res = {1'b0, value[7:1]};
      end
      default: begin
        res = value;
      end
    endcase
    return res;
  endfunction

  // ===========================================
  // Checks
  property p_left_carry;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_LEFT
      |=> shift_out_bit == $past(operand_data[7]);
  endproperty
  a_left_carry: assert property (p_left_carry)
    else $error("left shift carry wrong");

  property p_left_fill;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_LEFT && !instr.target_sel
      |=> acc_value == {$past(operand_data[6:0]), 1'b0};
  endproperty
  a_left_fill: assert property (p_left_fill)
    else $error("left shift result wrong");

  property p_target_reg;
    @(posedge clk) disable iff (rst)
    active && instr.target_sel
      |=> file_write.write_en && file_write.addr == $past(instr.addr)
          && $stable(acc_value);
  endproperty
  a_target_reg: assert property (p_target_reg)
    else $error("register target not written");

  property p_right_carry;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_RIGHT
      |=> shift_out_bit == $past(operand_data[0]);
  endproperty
  a_right_carry: assert property (p_right_carry)
    else $error("right shift carry wrong");

  property p_right_msb;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_RIGHT && instr.target_sel
      |=> file_write.data == {1'b0, $past(operand_data[7:1])};
  endproperty
  a_right_msb: assert property (p_right_msb)
    else $error("right shift result wrong");

  property p_addr;
    @(posedge clk) disable iff (rst)
    operand_addr == instr.addr && operand_addr <= shift_move_pkg::ADDR_MAX;
  endproperty
  a_addr: assert property (p_addr)
    else $error("operand address mismatch");

  property p_copy;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_COPY
      |=> $stable(shift_out_bit) && (file_write.write_en
          ? file_write.data == $past(operand_data)
          : acc_value == $past(operand_data));
  endproperty
  a_copy: assert property (p_copy)
    else $error("copy result wrong");

  property p_zero;
    @(posedge clk) disable iff (rst)
    active |=> null_result_flag
      == (expect_result($past(instr.op), $past(operand_data)) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_copy_zero;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_COPY && instr.target_sel
      |=> null_result_flag == ($past(operand_data) == 8'h00);
  endproperty
  a_copy_zero: assert property (p_copy_zero)
    else $error("copy zero test wrong");

  property p_target_acc;
    @(posedge clk) disable iff (rst)
    active && instr.target_sel == shift_move_pkg::TARGET_ACC
      |=> !file_write.write_en;
  endproperty
  a_target_acc: assert property (p_target_acc)
    else $error("accumulator target wrote register");

  property p_left_reg;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_LEFT && instr.target_sel
      |=> file_write.data == {$past(operand_data[6:0]), 1'b0};
  endproperty
  a_left_reg: assert property (p_left_reg)
    else $error("left shift write-back wrong");

  property p_right_acc;
    @(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_RIGHT && !instr.target_sel
      |=> acc_value == {1'b0, $past(operand_data[7:1])};
  endproperty
  a_right_acc: assert property (p_right_acc)
    else $error("right shift accumulator wrong");

  property p_idle;
    @(posedge clk) disable iff (rst)
    !active |=> $stable(null_result_flag) && $stable(acc_value)
      && !file_write.write_en;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle cycle changed state");

  c_left_reg: cover property (@(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_LEFT && instr.target_sel);
  c_right_acc: cover property (@(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_RIGHT && !instr.target_sel);
  c_copy_zero: cover property (@(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_COPY && instr.target_sel
    && operand_data == 8'h00);
  c_right_zero: cover property (@(posedge clk) disable iff (rst)
    instr.op == shift_move_pkg::OP_SHIFT_RIGHT && operand_data == 8'h01);

endmodule

`default_nettype wire

// *** verification/shift_and_move_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module shift_and_move_datapath_tb;
  logic clk;
  logic rst;
  shift_move_pkg::instr_type instr;
  logic [7:0] operand_data;
  logic [6:0] operand_addr;
  shift_move_pkg::file_write_type file_write;
  logic [7:0] acc_value;
  logic shift_out_bit;
  logic null_result_flag;
  int n_errors;
  int compares;

  shift_and_move_datapath u_dut (
    .clk(clk),
    .rst(rst),
    .instr(instr),
    .operand_data(operand_data),
    .operand_addr(operand_addr),
    .file_write(file_write),
    .acc_value(acc_value),
    .shift_out_bit(shift_out_bit),
    .null_result_flag(null_result_flag)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // =============================================
  // Checking helpers
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic expect_out(input logic [15:0] fw, input logic [7:0] a,
                            input logic c, input logic z);
    chk("file_write", fw, file_write);
    chk("acc_value", {8'h00, a}, {8'h00, acc_value});
    chk("shift_out_bit", {15'h0000, c}, {15'h0000, shift_out_bit});
    chk("null_result_flag", {15'h0000, z}, {15'h0000, null_result_flag});
  endtask

  // One instruction, then idle; operand bus scrambled once released
  task automatic exec(input shift_move_pkg::op_type op, input logic [6:0] a,
                      input logic t, input logic [7:0] d);
    @(posedge clk);
    #1;
    instr = '{op, a, t};
    operand_data = d;
    #1 chk("operand_addr", {9'h000, a}, {9'h000, operand_addr});
    @(posedge clk);
    #1;
    instr.op = shift_move_pkg::OP_NONE;
    operand_data = ~d;
  endtask

  // =============================================
  // Scenarios
  task automatic left_t;
    exec(shift_move_pkg::OP_SHIFT_LEFT, 7'h05, 1'b1, 8'h81);
    expect_out({1'b1, 7'h05, 8'h02}, 8'h00, 1'b1, 1'b0);
    exec(shift_move_pkg::OP_SHIFT_LEFT, 7'h00, 1'b0, 8'h80);
    expect_out(16'h0000, 8'h00, 1'b1, 1'b1);
    // Carry is 1 here, so a carry fed into bit 0 shows
    exec(shift_move_pkg::OP_SHIFT_LEFT, 7'h11, 1'b0, 8'h7f);
    expect_out(16'h0000, 8'hfe, 1'b0, 1'b0);
  endtask

  task automatic right_t;
    exec(shift_move_pkg::OP_SHIFT_RIGHT, 7'h01, 1'b0, 8'h02);
    expect_out(16'h0000, 8'h01, 1'b0, 1'b0);
    exec(shift_move_pkg::OP_SHIFT_RIGHT, 7'h02, 1'b0, 8'h01);
    expect_out(16'h0000, 8'h00, 1'b1, 1'b1);
    // Carry is 1 here, so a carry fed into bit 7 shows
    exec(shift_move_pkg::OP_SHIFT_RIGHT, 7'h7f, 1'b1, 8'hff);
    expect_out({1'b1, 7'h7f, 8'h7f}, 8'h00, 1'b1, 1'b0);
  endtask

  task automatic copy_t;
    exec(shift_move_pkg::OP_COPY, 7'h03, 1'b0, 8'h00);
    expect_out(16'h0000, 8'h00, 1'b1, 1'b1);
    exec(shift_move_pkg::OP_COPY, 7'h44, 1'b1, 8'ha5);
    expect_out({1'b1, 7'h44, 8'ha5}, 8'h00, 1'b1, 1'b0);
    exec(shift_move_pkg::OP_COPY, 7'h45, 1'b1, 8'h00);
    expect_out({1'b1, 7'h45, 8'h00}, 8'h00, 1'b1, 1'b1);
    exec(shift_move_pkg::OP_COPY, 7'h46, 1'b0, 8'h3c);
    expect_out(16'h0000, 8'h3c, 1'b1, 1'b0);
    // Idle cycle after the accumulator copy must hold state and raise no write pulse
    @(posedge clk);
    #1 expect_out(16'h0000, 8'h3c, 1'b1, 1'b0);
  endtask

  task automatic give_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    n_errors = 0;
    compares = 0;
    rst = 1'b1;
    instr = '{shift_move_pkg::OP_NONE, 7'h00, 1'b0};
    operand_data = 8'h00;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    expect_out(16'h0000, 8'h00, 1'b0, 1'b0);
    left_t();
    right_t();
    copy_t();
    give_verdict();
  end
endmodule

`default_nettype wire
